// *** core/pll_ratio_clock_select.sv ***
// core clock selection: ratio strap capture, mode control and clock markers
// Behaviour
// - decode six-bit code to 11x..28x, vco 1x
// - bypass code: pll off, reference clocks core
// - bypass: bus at half, core at full reference
// - off code stops all internal clocking
// - pll mode: decoded multiplier divided down by frequency switching
`include "pll_ratio_clock_select_regs.svh"

module pll_ratio_clock_select
  import clk_sel_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  // configuration straps and controls
  input  wire logic [5:0]                ratio_cfg_i,
  input  wire logic [1:0]                dynamic_frequency_switching_mode_i,
  // reference clock and bypass qualifier, sampled
  input  wire logic                      bus_reference_clock_i,
  input  wire logic                      bypass_bus_qualifier_i,
  // clock control outputs
  output logic                           pll_enable_o,
  output logic                           core_clock_run_o,
  output logic                           core_tick_o,
  output logic                           bus_tick_o,
  // status
  output clk_status_type                 status_o,
  output logic [`REF_PERIOD_W-1:0]       ref_period_o
);

  // control states
  typedef enum logic [1:0] {
    ST_CAPTURE,
    ST_PLL,
    ST_BYPASS,
    ST_HALT
  } ctrl_state_type;

  ctrl_state_type               state;
  ctrl_state_type               next_state;
  logic [5:0]                   cfg_code;
  logic [5:0]                   next_cfg_code;
  ratio_decode_type             decode;
  logic                         ref_prev;
  logic                         ref_rise;
  logic                         next_core_tick;
  logic                         next_bus_tick;
  logic                         next_pll_enable;
  logic                         next_core_run;
  logic [`REF_PERIOD_W-1:0]     period_cnt;
  logic [`REF_PERIOD_W-1:0]     next_period_cnt;
  logic [`REF_PERIOD_W-1:0]     next_ref_period;
  logic [7:0]                   eff_mult_x2;
  clk_status_type               next_status;
  logic                         pll_active;
  logic                         clocked_mode;
  logic                         low_ratio;

  // decode of the captured configuration code
  ratio_decoder u_decoder (
    .ratio_cfg_i (cfg_code),
    .decode_o    (decode)
  );

  // reference edge seen at the system clock
  assign ref_rise = bus_reference_clock_i & ~ref_prev;

  // mode qualifiers shared by the multiplier and status logic
  assign pll_active   = (decode.mode == MODE_PLL);
  assign clocked_mode = (decode.mode == MODE_PLL) || (decode.mode == MODE_BYPASS);
  assign low_ratio    = (eff_mult_x2 < `LOW_RATIO_X2); // address_acknowledge stretch zone

  // control state: the code is a strap, caught once after reset release
  always_comb begin
    next_state    = state;
    next_cfg_code = cfg_code;
    unique case (state)
      ST_CAPTURE: begin
        next_cfg_code = ratio_cfg_i;
        next_state    = ST_HALT;
        if (ratio_cfg_i == `RATIO_CODE_BYPASS) begin
          next_state = ST_BYPASS;
        end else if (ratio_cfg_i != `RATIO_CODE_OFF) begin
          // reserved codes also land here, then ST_PLL halts them a cycle later
          next_state = ST_PLL;
        end
      end
      ST_PLL: begin
        if (decode.mode != MODE_PLL) begin
          next_state = ST_HALT;
        end
      end
      ST_BYPASS:  next_state = ST_BYPASS;
      ST_HALT:    next_state = ST_HALT;
    endcase
  end

  // control state registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= ST_CAPTURE;
      cfg_code <= `RATIO_CODE_OFF;
    end else begin
      state    <= next_state;
      cfg_code <= next_cfg_code;
    end
  end

  // effective multiplier: decoded value divided down by frequency switching in pll mode only
  always_comb begin
    eff_mult_x2 = decode.mult_x2;
    if (pll_active) begin
      unique case (dynamic_frequency_switching_mode_i)
        `FREQ_SW_OFF:  eff_mult_x2 = decode.mult_x2;
        `FREQ_SW_DIV2: eff_mult_x2 = decode.mult_x2 >> 1;
        `FREQ_SW_DIV4: eff_mult_x2 = decode.mult_x2 >> 2;
        `FREQ_SW_DIV8: eff_mult_x2 = decode.mult_x2 >> 3;
      endcase
    end
  end

  // clock markers and enables for each state
  always_comb begin
    next_pll_enable = 1'b0;
    next_core_run   = 1'b0;
    next_core_tick  = 1'b0;
    next_bus_tick   = 1'b0;
    unique case (state)
      ST_CAPTURE: begin
        next_pll_enable = 1'b0;
      end
      ST_PLL: begin
        // pll runs; bus follows every reference edge
        next_pll_enable = (decode.mode == MODE_PLL);
        next_core_run   = (decode.mode == MODE_PLL);
        next_core_tick  = ref_rise & (decode.mode == MODE_PLL);
        next_bus_tick   = ref_rise & (decode.mode == MODE_PLL);
      end
      ST_BYPASS: begin
        // pll disabled; core on each edge, bus on qualified edges only
        next_pll_enable = 1'b0;
        next_core_run   = 1'b1;
        next_core_tick  = ref_rise;
        next_bus_tick   = ref_rise & bypass_bus_qualifier_i;
      end
      ST_HALT: begin
        next_pll_enable = 1'b0;
      end
    endcase
  end

  // clock marker registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_prev         <= 1'b0;
      pll_enable_o     <= 1'b0;
      core_clock_run_o <= 1'b0;
      core_tick_o      <= 1'b0;
      bus_tick_o       <= 1'b0;
    end else begin
      ref_prev         <= bus_reference_clock_i;
      pll_enable_o     <= next_pll_enable;
      core_clock_run_o <= next_core_run;
      core_tick_o      <= next_core_tick;
      bus_tick_o       <= next_bus_tick;
    end
  end

  // reference period measured in system clocks, rising edge to rising edge
  always_comb begin
    next_period_cnt = period_cnt;
    next_ref_period = ref_period_o;
    if (ref_rise) begin
      next_ref_period = period_cnt;
      next_period_cnt = `REF_PERIOD_W'(1);
    end else if (period_cnt != `REF_PERIOD_MAX) begin
      next_period_cnt = period_cnt + `REF_PERIOD_W'(1); // saturates
    end
  end

  // period registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_cnt   <= '0;
      ref_period_o <= '0;
    end else begin
      period_cnt   <= next_period_cnt;
      ref_period_o <= next_ref_period;
    end
  end

  // status word; snoop delay flag warns the bus controller at low ratios
  always_comb begin
    next_status                    = '0;
    next_status.vco_mult           = `VCO_MULT;
    next_status.mode               = MODE_OFF;
    // off is shown until the strap has been taken
    if (state != ST_CAPTURE) begin
      next_status.mode               = decode.mode;
      next_status.decoded_mult_x2    = decode.mult_x2;
      next_status.effective_mult_x2  = eff_mult_x2;
      next_status.cfg_reserved       = (decode.mode == MODE_RESERVED);
      next_status.snoop_delay_needed = clocked_mode & low_ratio;
    end
  end

  // status register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o <= next_status;
    end
  end

endmodule

// *** core/ratio_decoder.sv ***
// combinational decode of the six-bit ratio configuration code
`include "pll_ratio_clock_select_regs.svh"

module ratio_decoder
  import clk_sel_pkg::*;
(
  // configuration code
  input  wire logic [5:0]       ratio_cfg_i,
  // decoded mode and multiplier
  output ratio_decode_type      decode_o
);

  // lookup of every defined code; anything else is reserved
  always_comb begin
    decode_o.mode    = MODE_PLL;
    decode_o.mult_x2 = `MULT_X2_NONE;
    case (ratio_cfg_i)
      `RATIO_CODE_11X0:   decode_o.mult_x2 = `MULT_X2_11X0;
      `RATIO_CODE_11X5:   decode_o.mult_x2 = `MULT_X2_11X5;
      `RATIO_CODE_12X0:   decode_o.mult_x2 = `MULT_X2_12X0;
      `RATIO_CODE_12X5:   decode_o.mult_x2 = `MULT_X2_12X5;
      `RATIO_CODE_13X0:   decode_o.mult_x2 = `MULT_X2_13X0;
      `RATIO_CODE_13X5:   decode_o.mult_x2 = `MULT_X2_13X5;
      `RATIO_CODE_14X0:   decode_o.mult_x2 = `MULT_X2_14X0;
      `RATIO_CODE_15X0:   decode_o.mult_x2 = `MULT_X2_15X0;
      `RATIO_CODE_16X0:   decode_o.mult_x2 = `MULT_X2_16X0;
      `RATIO_CODE_17X0:   decode_o.mult_x2 = `MULT_X2_17X0;
      `RATIO_CODE_18X0:   decode_o.mult_x2 = `MULT_X2_18X0;
      `RATIO_CODE_20X0:   decode_o.mult_x2 = `MULT_X2_20X0;
      `RATIO_CODE_21X0:   decode_o.mult_x2 = `MULT_X2_21X0;
      `RATIO_CODE_24X0:   decode_o.mult_x2 = `MULT_X2_24X0;
      `RATIO_CODE_28X0:   decode_o.mult_x2 = `MULT_X2_28X0;
      `RATIO_CODE_BYPASS: begin
        decode_o.mode    = MODE_BYPASS;
        decode_o.mult_x2 = `MULT_X2_BYPASS;
      end
      `RATIO_CODE_OFF:    decode_o.mode = MODE_OFF;
      default:            decode_o.mode = MODE_RESERVED;
    endcase
  end

endmodule

// *** dv/pll_ratio_clock_select_assertions.sv ***
// port checker for the ratio clock select core
module pll_ratio_clock_select_chk
  import clk_sel_pkg::*;
(
  // clock, reset and reference inputs
  input wire logic           sys_clk_i,
  input wire logic           rst_i,
  input wire logic           bus_reference_clock_i,
  input wire logic           bypass_bus_qualifier_i,
  // observed outputs
  input wire logic           pll_enable_o,
  input wire logic           core_clock_run_o,
  input wire logic           core_tick_o,
  input wire logic           bus_tick_o,
  input wire clk_status_type status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // mode dependent enables and ticks
  off_quiet_a: assert property (
    status_o.mode == MODE_OFF |-> !(core_tick_o | bus_tick_o | core_clock_run_o))
    else $error("activity in off mode");
  bypass_direct_a: assert property (status_o.mode == MODE_BYPASS |-> !pll_enable_o && core_clock_run_o)
    else $error("bypass enables wrong");
  tick_on_rise_a: assert property (
    core_tick_o |-> $past(bus_reference_clock_i) && !$past(bus_reference_clock_i, 2))
    else $error("core tick without reference rise");
  bypass_half_a: assert property (
    status_o.mode == MODE_BYPASS && bus_tick_o |-> core_tick_o && $past(bypass_bus_qualifier_i))
    else $error("bypass bus tick without qualifier");
  // status is all zero out of reset, which reads as pll mode for one edge
  pll_bus_a: assert property (
    !$past(rst_i) && status_o.mode == MODE_PLL |-> bus_tick_o == core_tick_o && pll_enable_o)
    else $error("pll bus tick mismatch");
  vco_unity_a: assert property (!$past(rst_i) |-> status_o.vco_mult == 4'h1)
    else $error("vco multiplier not one");
  snoop_low_a: assert property (
    !$past(rst_i) && status_o.mode inside {MODE_PLL, MODE_BYPASS}
    |-> status_o.snoop_delay_needed == (status_o.effective_mult_x2 < 8'h0a))
    else $error("snoop delay flag wrong");
  reserved_halt_a: assert property (
    status_o.mode == MODE_RESERVED |-> status_o.cfg_reserved && !pll_enable_o && !core_tick_o)
    else $error("reserved code not halted");
  // main scenarios reached
  cover property (status_o.mode == MODE_BYPASS && bus_tick_o);
  cover property (status_o.mode == MODE_PLL && status_o.snoop_delay_needed);
  cover property (status_o.mode == MODE_RESERVED);
endmodule

bind pll_ratio_clock_select pll_ratio_clock_select_chk chk_u (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .bus_reference_clock_i(bus_reference_clock_i), .bypass_bus_qualifier_i(bypass_bus_qualifier_i),
  .pll_enable_o(pll_enable_o), .core_clock_run_o(core_clock_run_o),
  .core_tick_o(core_tick_o), .bus_tick_o(bus_tick_o), .status_o(status_o)
);

// *** dv/ref_clock_source.sv ***
// board reference clock and bypass qualifier source
module ref_clock_source (
  input  wire logic       sys_clk_i,
  input  wire logic [2:0] half_i,
  output logic            ref_o,
  output logic            qual_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    ref_o = 1'b0;
    qual_o = 1'b0;
  end
  // toggle reference every half_i cycles, off the sampling edge
  always @(negedge sys_clk_i) begin
    if (cnt + 1 >= half_i) begin
      cnt <= 0;
      ref_o <= !ref_o;
      if (ref_o) qual_o <= !qual_o; // half rate, moves at reference fall
    end else cnt <= cnt + 1;
  end
endmodule

// *** dv/tb_pll_ratio_clock_select.sv ***
// self-checking bench for the ratio clock select core
module tb_pll_ratio_clock_select
  import clk_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           sys_clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic [5:0]     ratio_cfg_i = 6'h26;
  logic [1:0]     freq_mode = 2'h0;
  logic [2:0]     half = 3'h2;
  logic           ref_clk, qual, pll_en, run, core_tick, bus_tick;
  logic           ref_q = 1'b0, rise = 1'b0, qual_at = 1'b0, chk_en = 1'b0;
  clk_status_type status;
  logic [15:0]    ref_period;
  int             rises [$];
  logic [16:0]    seed = 17'h10acf;
  logic [5:0]     codes [15] = '{6'h26, 6'h00, 6'h2e, 6'h3e, 6'h16, 6'h38, 6'h32, 6'h06,
                                 6'h36, 6'h02, 6'h0a, 6'h0e, 6'h12, 6'h1a, 6'h3a};
  int             mults [15] = '{22, 23, 24, 25, 26, 27, 28, 30, 32, 34, 36, 40, 42, 48, 56};
  int             errors = 0, checked = 0, cycles = 0, exp_mode, exp_mult;

  always #5 sys_clk_i = ~sys_clk_i;

  pll_ratio_clock_select dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ratio_cfg_i(ratio_cfg_i),
    .dynamic_frequency_switching_mode_i(freq_mode),
    .bus_reference_clock_i(ref_clk), .bypass_bus_qualifier_i(qual),
    .pll_enable_o(pll_en), .core_clock_run_o(run), .core_tick_o(core_tick),
    .bus_tick_o(bus_tick), .status_o(status), .ref_period_o(ref_period)
  );
  ref_clock_source src_u (.sys_clk_i(sys_clk_i), .half_i(half), .ref_o(ref_clk), .qual_o(qual));

  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // expected mode and multiplier of a code
  task automatic model(input logic [5:0] c);
    exp_mode = 3;
    exp_mult = 0;
    if (c == 6'h0c) begin
      exp_mode = 1;
      exp_mult = 4;
    end
    if (c == 6'h3c) exp_mode = 2;
    foreach (codes[i]) if (codes[i] == c) begin
      exp_mode = 0;
      exp_mult = mults[i];
    end
  endtask

  // reset with a code, then check status and every divider setting
  task automatic run_code(input logic [5:0] c);
    int eff;
    chk_en = 1'b0;
    @(negedge sys_clk_i);
    model(c);
    seed = lfsr(seed);
    half = 3'h1 + {1'b0, seed[7:6]};
    ratio_cfg_i = c;
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk_en = 1'b1;
    check("mode", 16'(status.mode), 16'(exp_mode));
    check("mult", 16'(status.decoded_mult_x2), 16'(exp_mult));
    check("pll_en", 16'(pll_en), 16'(exp_mode == 0));
    check("run", 16'(run), 16'(exp_mode < 2));
    check("reserved", 16'(status.cfg_reserved), 16'(exp_mode == 3));
    for (int d = 0; d < 4; d++) begin
      freq_mode = d[1:0];
      repeat (12) @(negedge sys_clk_i);
      eff = (exp_mode == 0) ? (exp_mult >> d) : 4;
      if (exp_mode < 2) begin
        check("eff", 16'(status.effective_mult_x2), 16'(eff));
        check("snoop", 16'(status.snoop_delay_needed), 16'(eff < 10));
      end
    end
    check("period", ref_period, 16'(rises[1] - rises[0]));
    freq_mode = 2'h0;
  endtask

  // reference rise seen by the model
  always @(posedge sys_clk_i) begin
    ref_q <= ref_clk;
    rise <= ref_clk && !ref_q;
    // cycle numbers of the last two reference rises
    if (ref_clk && !ref_q) begin
      rises.push_back(cycles);
      if (rises.size() > 2) void'(rises.pop_front());
    end
    qual_at <= qual;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // tick comparison every cycle while chk_en is set
  always @(negedge sys_clk_i) begin
    if (chk_en) begin
      check("core_tick", 16'(core_tick), 16'(rise && exp_mode < 2));
      check("bus_tick", 16'(bus_tick), 16'(rise && (exp_mode == 0 || (exp_mode == 1 && qual_at))));
    end
  end

  initial begin
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
    foreach (codes[i]) run_code(codes[i]);
    run_code(6'h0c);
    run_code(6'h3c);
    run_code(6'h3f);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      run_code(seed[5:0]);
    end
    final_report();
  end
endmodule

// *** pkg/clk_sel_pkg.sv ***
// types shared by the ratio decoder and the clock select core
package clk_sel_pkg;

  // clocking modes chosen by the ratio code
  typedef enum logic [1:0] {
    MODE_PLL,
    MODE_BYPASS,
    MODE_OFF,
    MODE_RESERVED
  } clk_mode_type;

  // result of decoding one ratio code
  typedef struct packed {
    clk_mode_type mode;
    logic [7:0]   mult_x2;
  } ratio_decode_type;

  // status reported to the rest of the processor
  typedef struct packed {
    clk_mode_type mode;
    logic [7:0]   decoded_mult_x2;
    logic [7:0]   effective_mult_x2;
    logic [3:0]   vco_mult;
    logic         cfg_reserved;
    logic         snoop_delay_needed;
  } clk_status_type;

endpackage

// *** pkg/pll_ratio_clock_select_regs.svh ***
// constants for the core clock ratio selection logic
`ifndef PLL_RATIO_CLOCK_SELECT_REGS_SVH
`define PLL_RATIO_CLOCK_SELECT_REGS_SVH

// six-bit ratio configuration codes
`define RATIO_CODE_11X0   6'h26
`define RATIO_CODE_11X5   6'h00
`define RATIO_CODE_12X0   6'h2e
`define RATIO_CODE_12X5   6'h3e
`define RATIO_CODE_13X0   6'h16
`define RATIO_CODE_13X5   6'h38
`define RATIO_CODE_14X0   6'h32
`define RATIO_CODE_15X0   6'h06
`define RATIO_CODE_16X0   6'h36
`define RATIO_CODE_17X0   6'h02
`define RATIO_CODE_18X0   6'h0a
`define RATIO_CODE_20X0   6'h0e
`define RATIO_CODE_21X0   6'h12
`define RATIO_CODE_24X0   6'h1a
`define RATIO_CODE_28X0   6'h3a
`define RATIO_CODE_BYPASS 6'h0c
`define RATIO_CODE_OFF    6'h3c

// bus-to-core multipliers in half units (value = 2 x multiplier)
`define MULT_X2_11X0   8'h16
`define MULT_X2_11X5   8'h17
`define MULT_X2_12X0   8'h18
`define MULT_X2_12X5   8'h19
`define MULT_X2_13X0   8'h1a
`define MULT_X2_13X5   8'h1b
`define MULT_X2_14X0   8'h1c
`define MULT_X2_15X0   8'h1e
`define MULT_X2_16X0   8'h20
`define MULT_X2_17X0   8'h22
`define MULT_X2_18X0   8'h24
`define MULT_X2_20X0   8'h28
`define MULT_X2_21X0   8'h2a
`define MULT_X2_24X0   8'h30
`define MULT_X2_28X0   8'h38
// bypass: core at reference, bus at half reference
`define MULT_X2_BYPASS 8'h04
`define MULT_X2_NONE   8'h00
// vco multiplier is always 1x
`define VCO_MULT       4'h1

// below this multiplier the bus controller must stretch address acknowledge
`define LOW_RATIO_X2   8'h0a

// dynamic frequency switching divider codes
`define FREQ_SW_OFF    2'h0
`define FREQ_SW_DIV2   2'h1
`define FREQ_SW_DIV4   2'h2
`define FREQ_SW_DIV8   2'h3

// reference period counter width and saturation
`define REF_PERIOD_W   16
`define REF_PERIOD_MAX 16'hffff

`endif
